// File: shared/sto_pkg.sv
// package: constants and types shared by both ends of the torque-cut link
package sto_pkg;

  // clock period in picoseconds (250 MHz)
  localparam int unsigned CLOCK_PERIOD_PS = 4000;

  // longest diagnostic open pulse the far end may apply, in microseconds
  localparam int unsigned TEST_PULSE_US = 1000;
  // cycles covering one test pulse; a filter must outlast it
  localparam int unsigned TEST_PULSE_CYCLES =
    (TEST_PULSE_US * 1000000) / CLOCK_PERIOD_PS;
  // open must persist one cycle past the longest test pulse to count
  localparam int unsigned OPEN_FILTER_CYCLES = TEST_PULSE_CYCLES + 1;

  // alarm code reported by the timing check
  localparam logic [7:0] CUT_TIMING_ALARM_CODE = 8'h63;

  // reset values
  localparam logic INPUT_RESET_LEVEL    = 1'b0;
  localparam logic FEEDBACK_RESET_LEVEL = 1'b1;

  // far-end sequencer states
  typedef enum logic [3:0] {
    STO_CTL_CUT     = 4'h1,
    STO_CTL_ARMED   = 4'h2,
    STO_CTL_RUN     = 4'h4,
    STO_CTL_STOPPING = 4'h8
  } sto_ctl_state_t;

endpackage : sto_pkg

// File: shared/sto_link_if.sv
// interface: the two cut inputs and the two feedback contacts
`timescale 1ns/10ps
interface sto_link_if;
  // high means the contact between the input and its common is closed
  logic torque_cut_input_a;
  logic torque_cut_input_b;
  // high means the feedback contact to cut_feedback_common is closed
  logic cut_feedback_a;
  logic cut_feedback_b;

  modport device_end (
    input  torque_cut_input_a,
    input  torque_cut_input_b,
    output cut_feedback_a,
    output cut_feedback_b
  );

  modport control_end (
    output torque_cut_input_a,
    output torque_cut_input_b,
    input  cut_feedback_a,
    input  cut_feedback_b
  );
endinterface : sto_link_if

// File: core/sto_device.sv
// device end: filters cut inputs, drives feedback, gates base drive
`timescale 1ns/10ps

// Overview of operation
// R01: open input requests cut, closed permits drive
// R02: feedback a closed exactly while input a open
// R03: feedback b closed exactly while input b open
// R04: series feedback conducts only with both open
// R05: base drive released only with both closed
// R06: far end keeps test pulses within 1 ms
// R07: open while running: dynamic brake, alarm
// R08: far end opens inputs after motor stops
// R09: far end opens both inputs together
// R10: safety unit release needs pulsed release inputs
// R11: controller asserts safety outputs after stop
// R12: emergency open while rotating: stop, alarm
// R13: ignore open pulses within test pulse time
// R14: running means base driving and speed nonzero
module sto_device
  import sto_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  sto_link_if.device_end   link,
  input  wire logic        motor_speed_nonzero,
  input  wire logic        alarm_clear,
  output logic             base_drive_enable,
  output logic             dynamic_brake,
  output logic             cut_timing_alarm,
  output logic [7:0]       alarm_code,
  output logic             channel_a_open,
  output logic             channel_b_open
);

  localparam int unsigned CW = $clog2(OPEN_FILTER_CYCLES + 1);
  localparam logic [CW-1:0] FILTER_END = CW'(OPEN_FILTER_CYCLES);

  logic [1:0] raw_in;
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] sync3;
  logic [1:0] open_filt;
  logic [1:0] fb_q;

  assign raw_in = {link.torque_cut_input_b, link.torque_cut_input_a};

  ////////////////////////////////////////////////////////////////////////////
  // either channel asking for the cut; shared by drive, alarm and brake
  function automatic logic any_channel_open(input logic [1:0] chan);
    any_channel_open = |chan;
  endfunction : any_channel_open

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers; sync1 feeds only sync2
  // a change counts only once stages two and three agree, which keeps a
  // metastable first stage out of the filter
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sync1 <= {2{INPUT_RESET_LEVEL}};
      sync2 <= {2{INPUT_RESET_LEVEL}};
      sync3 <= {2{INPUT_RESET_LEVEL}};
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel filter: opening must outlast the longest test pulse, so a
  // diagnostic pulse never drops the drive; closing acts at once, which
  // only lets the drive come back sooner
  // limitation: while stages two and three disagree the count holds, so a
  // one-cycle closed glitch neither restarts nor advances the filter
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      logic [CW-1:0] open_cnt;
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          open_cnt     <= '0;
          open_filt[g] <= 1'b1;                       // reset in cut state
        end else if (sync2[g] == sync3[g]) begin
          if (sync3[g]) begin
            open_cnt     <= '0;
            open_filt[g] <= 1'b0;                     // R01
          end else if (open_cnt >= FILTER_END - CW'(1)) begin
            open_filt[g] <= 1'b1;                     // R01 R13
          end else begin
            open_cnt <= open_cnt + CW'(1);            // R13
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // feedback contacts, each follows its own channel only
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      fb_q <= {2{FEEDBACK_RESET_LEVEL}};
    end else begin
      fb_q[0] <= open_filt[0];                        // R02 R04
      fb_q[1] <= open_filt[1];                        // R03 R04
    end
  end
  assign link.cut_feedback_a = fb_q[0];
  assign link.cut_feedback_b = fb_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // status copies for the host side
  // they mirror the filtered state on the same edge as the feedback, so
  // the host sees exactly what the contacts report
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      channel_a_open <= 1'b1;
      channel_b_open <= 1'b1;
    end else begin
      channel_a_open <= open_filt[0];
      channel_b_open <= open_filt[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // base drive: released only with both channels closed and no alarm;
  // the alarm latches so a running cut cannot silently restart
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      base_drive_enable <= 1'b0;
    end else begin
      base_drive_enable <= ~any_channel_open(open_filt)
                           & ~cut_timing_alarm;       // R05
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timing check: any cut request while driving a moving motor
  // limitation: speed is seen only as zero or not, so any nonzero speed
  // with base drive on counts as running; a raised alarm wins over a clear
  logic running;
  assign running = base_drive_enable & motor_speed_nonzero;  // R14

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cut_timing_alarm <= 1'b0;
      alarm_code       <= 8'h00;
    end else if (running && any_channel_open(open_filt)) begin
      cut_timing_alarm <= 1'b1;                       // R07 R12
      alarm_code       <= CUT_TIMING_ALARM_CODE;      // R07
    end else if (alarm_clear && any_channel_open(open_filt)) begin
      // clear only while cut is held, so the drive stays off meanwhile
      cut_timing_alarm <= 1'b0;
      alarm_code       <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dynamic brake: category zero stop while cut and motor still moving
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      dynamic_brake <= 1'b0;
    end else begin
      dynamic_brake <= (any_channel_open(open_filt) | cut_timing_alarm)
                       & motor_speed_nonzero;          // R07 R12
    end
  end

endmodule : sto_device

// File: core/sto_controller.sv
// controller end: sequences stop before cut, pulsed release
`timescale 1ns/10ps
module sto_controller
  import sto_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  sto_link_if.control_end  link,
  input  wire logic        cut_request,
  input  wire logic        release_input_a,
  input  wire logic        release_input_b,
  input  wire logic        motor_stopped,
  output logic             forced_stop_two,
  output logic             cut_active,
  output logic             feedback_fault
);

  sto_ctl_state_t state;
  logic [1:0]     fb_s1;
  logic [1:0]     fb_s2;
  logic [1:0]     fb_s3;
  logic           drive_q;

  ////////////////////////////////////////////////////////////////////////////
  // feedback synchronisers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      fb_s1 <= 2'h3;
      fb_s2 <= 2'h3;
      fb_s3 <= 2'h3;
    end else begin
      fb_s1 <= {link.cut_feedback_b, link.cut_feedback_a};
      fb_s2 <= fb_s1;
      fb_s3 <= fb_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: release needs both release inputs on then off;
  // cut waits for the motor to stop under forced stop two
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state <= STO_CTL_CUT;
    end else begin
      unique case (state)
        STO_CTL_CUT: begin
          if (release_input_a && release_input_b && !cut_request) begin
            state <= STO_CTL_ARMED;                   // R10
          end
        end
        STO_CTL_ARMED: begin
          if (cut_request) begin
            state <= STO_CTL_CUT;
          end else if (!release_input_a && !release_input_b) begin
            state <= STO_CTL_RUN;                     // R10
          end
        end
        STO_CTL_RUN: begin
          if (cut_request) begin
            state <= STO_CTL_STOPPING;
          end
        end
        STO_CTL_STOPPING: begin
          if (motor_stopped) begin
            state <= STO_CTL_CUT;                     // R08 R11
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one flop drives both inputs, so they always open together; they stay
  // closed through the stop so a turning motor is never cut
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= (state == STO_CTL_RUN) ||
                 (state == STO_CTL_STOPPING);         // R08 R09
    end
  end
  assign link.torque_cut_input_a = drive_q;           // R09
  assign link.torque_cut_input_b = drive_q;           // R09

  ////////////////////////////////////////////////////////////////////////////
  // forced stop two deasserted (low) to decelerate before the cut
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      forced_stop_two <= 1'b0;
      cut_active      <= 1'b1;
      feedback_fault  <= 1'b0;
    end else begin
      forced_stop_two <= (state == STO_CTL_RUN);      // R08
      cut_active      <= !drive_q;
      // feedback halves must agree once settled; disagreement is a fault
      feedback_fault  <= (fb_s2 == fb_s3) && (fb_s3[0] != fb_s3[1]);
    end
  end

endmodule : sto_controller

// File: verif/sto_link_props.sv
// checker: wire timing between the controller end and the device end
`timescale 1ns/10ps
module sto_link_props
  import sto_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic torque_cut_input_a,
  input wire logic torque_cut_input_b,
  input wire logic cut_feedback_a,
  input wire logic cut_feedback_b
);
  // an open run must outlast the longest test pulse before feedback closes
  localparam logic [19:0] PULSE_LIMIT = 20'(TEST_PULSE_CYCLES);
  // feedback must be closed this far into an open run (filter plus sync)
  localparam logic [19:0] CUT_SETTLED = PULSE_LIMIT + 20'h00008;
  logic [19:0] low_a;
  logic [19:0] low_b;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////////////////////////////////////
  // length of the current open run on each input, saturating
  always_ff @(posedge clock) begin
    if (!reset_n || torque_cut_input_a) low_a <= '0;
    else if (low_a != 20'hFFFFF) low_a <= low_a + 20'h00001;
  end
  always_ff @(posedge clock) begin
    if (!reset_n || torque_cut_input_b) low_b <= '0;
    else if (low_b != 20'hFFFFF) low_b <= low_b + 20'h00001;
  end
  //////////////////////////////////////////////////////////////////////////
  fb_a_close_a: assert property (torque_cut_input_a [*8]
    |-> !cut_feedback_a)
    else $error("feedback a closed while input a closed");
  fb_b_close_a: assert property (torque_cut_input_b [*8]
    |-> !cut_feedback_b)
    else $error("feedback b closed while input b closed");
  fb_a_cut_a: assert property (low_a == CUT_SETTLED
    |-> cut_feedback_a)
    else $error("feedback a open after a long open");
  fb_b_cut_a: assert property (low_b == CUT_SETTLED
    |-> cut_feedback_b)
    else $error("feedback b open after a long open");
  open_filter_a: assert property ($rose(cut_feedback_a)
    |-> low_a > PULSE_LIMIT)
    else $error("feedback a rose after a short open");
  filter_b_a: assert property ($rose(cut_feedback_b)
    |-> low_b > PULSE_LIMIT)
    else $error("feedback b rose after a short open");
  series_open_a: assert property (((torque_cut_input_a ||
    torque_cut_input_b) && $stable({torque_cut_input_a,
    torque_cut_input_b})) [*8] |-> !(cut_feedback_a && cut_feedback_b))
    else $error("series path conducts with an input closed");
  pair_equal_a: assert property (
    torque_cut_input_a == torque_cut_input_b)
    else $error("cut inputs differ");
  reset_cut_a: assert property ($rose(reset_n)
    |-> cut_feedback_a && cut_feedback_b)
    else $error("feedback not cut after reset");
  reset_open_a: assert property ($rose(reset_n)
    |-> !torque_cut_input_a && !torque_cut_input_b)
    else $error("inputs not open after reset");
  //////////////////////////////////////////////////////////////////////////
  release_c: cover property ($rose(torque_cut_input_a));
  drive_c: cover property ($fell(cut_feedback_a));
  cut_c: cover property ($rose(cut_feedback_b));
endmodule : sto_link_props

// File: verif/safe_torque_off_monitor_tb_top.sv
// testbench: both ends joined, plus a second device driven by hand
`timescale 1ns/10ps
module safe_torque_off_monitor_tb_top
  import sto_pkg::*;
;
  logic clock, reset_n, speed, clr, cut_req, rel, stopped;
  logic base, alarm, fst, cact, ffault, base2, brake2, alarm2, cha2, chb2;
  logic [7:0] code2;
  int   mismatches, comparisons;
  sto_link_if link ();
  sto_link_if link2 ();
  //////////////////////////////////////////////////////////////////////////
  sto_controller u_sto_controller (.clock(clock), .reset_n(reset_n),
    .link(link.control_end), .cut_request(cut_req),
    .release_input_a(rel), .release_input_b(rel), .motor_stopped(stopped),
    .forced_stop_two(fst), .cut_active(cact), .feedback_fault(ffault));
  // motor held still here: the running case is on the second device
  sto_device u_sto_device (.clock(clock), .reset_n(reset_n),
    .link(link.device_end), .motor_speed_nonzero(1'b0), .alarm_clear(1'b0),
    .base_drive_enable(base), .dynamic_brake(), .cut_timing_alarm(alarm),
    .alarm_code(), .channel_a_open(), .channel_b_open());
  sto_device u_sto_device_b (.clock(clock), .reset_n(reset_n),
    .link(link2.device_end), .motor_speed_nonzero(speed), .alarm_clear(clr),
    .base_drive_enable(base2), .dynamic_brake(brake2),
    .cut_timing_alarm(alarm2), .alarm_code(code2), .channel_a_open(cha2),
    .channel_b_open(chb2));
  sto_link_props u_sto_link_props (.clock(clock), .reset_n(reset_n),
    .torque_cut_input_a(link.torque_cut_input_a),
    .torque_cut_input_b(link.torque_cut_input_b),
    .cut_feedback_a(link.cut_feedback_a),
    .cut_feedback_b(link.cut_feedback_b));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // a release pulse cut short by a request must not release the drive
  task automatic t_release();
    int n;
    rel = 1'b1;
    @(negedge clock);
    cut_req = 1'b1;
    @(negedge clock);
    {cut_req, rel} = 2'b00;
    repeat (10) @(negedge clock);
    chk(link.torque_cut_input_a, 1'b0);
    rel = 1'b1;
    repeat (10) @(negedge clock);
    chk(link.torque_cut_input_a, 1'b0);
    rel = 1'b0;
    for (n = 0; n < 30 && base !== 1'b1; n++) @(negedge clock);
    chk(base, 1'b1);
    chk({link.cut_feedback_a, link.cut_feedback_b}, 2'b00);
    chk({fst, cact}, 2'b10);
    chk(ffault, 1'b0);
  endtask : t_release
  // single channel, then an open pulse as long as the longest test pulse
  task automatic t_single();
    link2.torque_cut_input_b = 1'b1;
    repeat (10) @(negedge clock);
    chk({link2.cut_feedback_a, link2.cut_feedback_b, base2}, 3'b100);
    link2.torque_cut_input_a = 1'b1;
    repeat (10) @(negedge clock);
    chk(base2, 1'b1);
    link2.torque_cut_input_a = 1'b0;
    repeat (TEST_PULSE_CYCLES) @(negedge clock);
    link2.torque_cut_input_a = 1'b1;
    repeat (10) @(negedge clock);
    chk({link2.cut_feedback_a, cha2, chb2, base2}, 4'b0001);
  endtask : t_single
  task automatic t_alarm();
    int n;
    speed = 1'b1;
    link2.torque_cut_input_a = 1'b0;
    link2.torque_cut_input_b = 1'b0;
    for (n = 0; n < 250100 && alarm2 !== 1'b1; n++) @(negedge clock);
    repeat (2) @(negedge clock);
    chk(code2, CUT_TIMING_ALARM_CODE);
    chk({alarm2, base2, brake2}, 3'b101);
    chk({link2.cut_feedback_a, link2.cut_feedback_b}, 2'b11);
    speed = 1'b0;
    clr = 1'b1;
    @(negedge clock);
    clr = 1'b0;
    repeat (4) @(negedge clock);
    chk({7'h00, alarm2}, 8'h00);
    chk(code2, 8'h00);
    chk({base2, brake2}, 2'b00);
  endtask : t_alarm
  // stop comes before the cut; a still motor raises no alarm
  task automatic t_stop();
    int n;
    cut_req = 1'b1;
    repeat (50) @(negedge clock);
    chk({fst, link.torque_cut_input_a}, 2'b01);
    stopped = 1'b1;
    repeat (5) @(negedge clock);
    chk({link.torque_cut_input_a, link.torque_cut_input_b}, 2'b00);
    for (n = 0; n < 250100 && link.cut_feedback_b !== 1'b1; n++)
      @(negedge clock);
    repeat (8) @(negedge clock);
    chk({link.cut_feedback_a, base, alarm}, 3'b100);
    chk({cact, ffault}, 2'b10);
  endtask : t_stop
  //////////////////////////////////////////////////////////////////////////
  // clock source
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // watchdog sized for two filter lengths plus margin
  initial begin
    repeat (600000) @(posedge clock);
    mismatches++;
    results();
  end
  // main sequence; the two long opens run side by side to save time
  initial begin
    {reset_n, speed, clr, cut_req, rel, stopped} = 6'h00;
    link2.torque_cut_input_a = 1'b0;
    link2.torque_cut_input_b = 1'b0;
    mismatches = 0;
    comparisons = 0;
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    chk({base, link.cut_feedback_a, link.cut_feedback_b}, 3'b011);
    t_release();
    t_single();
    fork
      t_alarm();
      t_stop();
    join
    results();
  end
endmodule : safe_torque_off_monitor_tb_top
